/* File: rtl/flash_self_program_pkg.sv */
/*
  constants, field positions, timing counts and state codes of the flash
  self-programming sequencer.
  assumes a 50 MHz pclk and a 32-bit APB register bus.
*/
package flash_self_program_pkg;

  // register map
  localparam logic [11:0] CTRL_ADDR        = 12'h000;

  // program_store_control_register bit positions
  localparam int          BIT_IRQ_EN       = 7;
  localparam int          BIT_BUSY         = 6;
  localparam int          BIT_RWW_RE       = 4;
  localparam int          BIT_LOCK_SET     = 3;
  localparam int          BIT_PAGE_WRITE   = 2;
  localparam int          BIT_PAGE_ERASE   = 1;
  localparam int          BIT_SPM_EN       = 0;

  // command patterns on bits 4:0 (bit 7 ignored)
  localparam logic [4:0]  CMD_LOAD         = 5'h01;
  localparam logic [4:0]  CMD_ERASE        = 5'h03;
  localparam logic [4:0]  CMD_WRITE        = 5'h05;
  localparam logic [4:0]  CMD_LOCK         = 5'h09;
  localparam logic [4:0]  CMD_RWW_RE       = 5'h11;

  // timed windows, in clock cycles after the control write
  localparam logic [2:0]  SPM_WINDOW       = 3'h4;
  localparam logic [2:0]  LPM_WINDOW       = 3'h3;
  localparam logic [2:0]  LPM_WIN_LAST     = 3'(SPM_WINDOW - LPM_WINDOW + 3'h1);

  // z pointer layout
  localparam int          Z_PAGE_MSB       = 14;
  localparam int          Z_PAGE_LSB       = 7;
  localparam int          Z_WORD_MSB       = 6;
  localparam int          Z_WORD_LSB       = 1;
  localparam logic [15:0] Z_LOCK_BYTE      = 16'h0001;
  localparam logic [15:0] Z_FUSE_LOW       = 16'h0000;
  localparam logic [15:0] Z_FUSE_HIGH      = 16'h0003;

  // page geometry
  localparam int          PAGE_WORDS       = 64;
  localparam logic [7:0]  NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE  = 8'hE0;

  // lock bits sit in bits 5:2 of r0 and of the lock byte
  localparam int          LOCK_MSB         = 5;
  localparam int          LOCK_LSB         = 2;
  localparam logic [3:0]  LOCK_RESET       = 4'hF;
  localparam logic [15:0] ERASED_WORD      = 16'hFFFF;

  // programming time, timed by a 1 us enable
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          TICK_NS          = 1000;
  localparam int          PROG_TIME_MIN_NS = 3700000;
  localparam int          PROG_TIME_MAX_NS = 4500000;
  localparam int          US_CYCLES        = TICK_NS / CLK_PERIOD_NS;
  localparam int          PROG_TICKS       = (PROG_TIME_MIN_NS + TICK_NS - 1) / TICK_NS;
  localparam logic [5:0]  DIV_LAST         = 6'(US_CYCLES - 1);
  localparam logic [11:0] TICK_LAST        = 12'(PROG_TICKS - 1);

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_RUN  = 2'b01,
    E_DONE = 2'b10
  } eng_state_t;

  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_WRITE = 2'b01,
    OP_LOCK  = 2'b10
  } op_t;

endpackage

/* File: rtl/flash_self_program_sequencer.sv */
/*
  flash self-programming sequencer: control register on APB, timed store and
  load program instruction windows, temporary page buffer, erase/write/lock
  programming engine and lock/fuse readback.
  assumes the core gives one-cycle spm_exec / lpm_exec pulses with z pointer
  and r0 valid, and that por_n is a power-on reset separate from presetn.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_sequencer
  import flash_self_program_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spm_exec,
  input  wire logic        lpm_exec,
  input  wire logic [15:0] z_ptr,
  input  wire logic [15:0] r_data,
  input  wire logic        global_irq_en,
  input  wire logic        eeprom_busy,
  input  wire logic        eeprom_write_start,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [5:0]  buf_raddr,
  output logic      [15:0] buf_rdata,
  output logic      [7:0]  lpm_data,
  output logic             lpm_hit,
  output logic             flash_busy,
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_lock,
  output logic      [7:0]  flash_page,
  output logic             flash_done,
  output logic      [3:0]  lock_bits,
  output logic             section_busy_flag,
  output logic             rww_read_block,
  output logic             cpu_halt,
  output logic             irq
);

  typedef struct packed {
    logic        irq_en;
    logic        busy;
    logic        lock_set;
    logic        page_write;
    logic        page_erase;
    logic        spm_en;
    logic [2:0]  win;
    logic        clr_pend;
    logic [31:0] prdata;
    logic [7:0]  lpm_data;
    logic        lpm_hit;
  } ctl_t;

  typedef struct packed {
    eng_state_t  state;
    op_t         op;
    logic [7:0]  page;
    logic        no_read_while_write_section;
    logic [3:0]  lock_new;
    logic [5:0]  div;
    logic [11:0] ticks;
    logic [3:0]  lock_bits;
    logic [63:0] mask;
    logic [15:0] rdata;
  } eng_t;

  ctl_t        ctl_q;
  ctl_t        ctl_d;
  eng_t        eng_q;
  eng_t        eng_d;
  logic [15:0] buf_mem [PAGE_WORDS];

  logic        addr_hit;
  logic        apb_wr;
  logic        eng_idle;
  logic        spm_ok;
  logic        lpm_ok;
  logic        start_op;
  op_t         start_kind;
  logic        load_word;
  logic        buf_clear;
  logic [5:0]  word_sel;
  logic [7:0]  page_sel;
  logic [7:0]  ctrl_byte;
  // erase or write of the read-while-write section is running
  logic        rww_active;

  assign addr_hit  = (paddr == CTRL_ADDR);
  assign apb_wr    = psel & penable & pwrite & addr_hit;
  assign eng_idle  = (eng_q.state == E_IDLE);
  assign word_sel  = z_ptr[Z_WORD_MSB:Z_WORD_LSB];
  assign page_sel  = z_ptr[Z_PAGE_MSB:Z_PAGE_LSB];
  // section busy while its op runs
  assign rww_active = ~eng_idle & ~eng_q.no_read_while_write_section & (eng_q.op != OP_LOCK);

  assign spm_ok    = spm_exec & ctl_q.spm_en & (ctl_q.win != 3'h0) & ~eeprom_busy & eng_idle;
  assign lpm_ok    = lpm_exec & ctl_q.spm_en & ctl_q.lock_set & (ctl_q.win >= LPM_WIN_LAST)
                     & ~eeprom_busy & eng_idle;

  assign ctrl_byte = {ctl_q.irq_en, ctl_q.busy | rww_active, 1'b0, 1'b0, ctl_q.lock_set,
                      ctl_q.page_write, ctl_q.page_erase, ctl_q.spm_en};

  always_comb begin
    ctl_d      = ctl_q;
    start_op   = 1'b0;
    start_kind = OP_ERASE;
    load_word  = 1'b0;
    buf_clear  = 1'b0;
    ctl_d.lpm_hit = 1'b0;

    if (psel & ~penable) begin
      ctl_d.prdata = addr_hit ? {24'h000000, ctrl_byte} : 32'h00000000;
    end

    if (ctl_q.win != 3'h0) begin
      ctl_d.win = ctl_q.win - 3'h1;
    end

    if ((ctl_q.win == 3'h1) & ~spm_ok & ~lpm_ok & eng_idle) begin
      ctl_d.spm_en     = 1'b0;
      ctl_d.lock_set   = 1'b0;
      ctl_d.page_write = 1'b0;
      ctl_d.page_erase = 1'b0;
    end

    if (spm_ok) begin
      ctl_d.win = 3'h0;
      if (ctl_q.lock_set) begin
        start_op   = 1'b1;
        start_kind = OP_LOCK;
      end else if (ctl_q.page_erase) begin
        start_op   = 1'b1;
        start_kind = OP_ERASE;
        ctl_d.busy = ctl_q.busy | (page_sel < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
      end else if (ctl_q.page_write) begin
        start_op   = 1'b1;
        start_kind = OP_WRITE;
        ctl_d.busy = ctl_q.busy | (page_sel < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
      end else begin
        load_word    = 1'b1;
        ctl_d.spm_en = 1'b0;
        ctl_d.busy   = 1'b0;
      end
    end

    if (lpm_ok) begin
      ctl_d.lpm_hit = 1'b1;
      case (z_ptr)
        Z_LOCK_BYTE: ctl_d.lpm_data = {2'b11, eng_q.lock_bits, 2'b11};
        Z_FUSE_LOW:  ctl_d.lpm_data = fuse_low_byte;
        Z_FUSE_HIGH: ctl_d.lpm_data = fuse_high_byte;
        default:     ctl_d.lpm_hit  = 1'b0;
      endcase
      if (ctl_d.lpm_hit) begin
        ctl_d.spm_en   = 1'b0;
        ctl_d.lock_set = 1'b0;
        ctl_d.win      = 3'h0;
      end
    end

    if (eng_q.state == E_DONE) begin
      ctl_d.spm_en     = 1'b0;
      ctl_d.lock_set   = 1'b0;
      ctl_d.page_write = 1'b0;
      ctl_d.page_erase = 1'b0;
    end

    if (eng_idle) begin
      ctl_d.clr_pend = 1'b0;
    end

    // flag set again after a system reset in mid-op
    // so the section stays fenced until software releases it
    if (rww_active) begin
      ctl_d.busy = 1'b1;
    end

    if (apb_wr) begin
      ctl_d.irq_en = pwdata[BIT_IRQ_EN];
      if (~ctl_q.spm_en & ~eeprom_busy & eng_idle) begin
        case (pwdata[4:0])
          CMD_LOAD: begin
            ctl_d.spm_en = 1'b1;
            ctl_d.win    = SPM_WINDOW;
          end
          CMD_ERASE: begin
            ctl_d.spm_en     = 1'b1;
            ctl_d.page_erase = 1'b1;
            ctl_d.win        = SPM_WINDOW;
          end
          CMD_WRITE: begin
            ctl_d.spm_en     = 1'b1;
            ctl_d.page_write = 1'b1;
            ctl_d.win        = SPM_WINDOW;
          end
          CMD_LOCK: begin
            ctl_d.spm_en   = 1'b1;
            ctl_d.lock_set = 1'b1;
            ctl_d.win      = SPM_WINDOW;
          end
          CMD_RWW_RE: begin
            buf_clear  = 1'b1;
            ctl_d.busy = 1'b0;
          end
          default: begin
            ctl_d.win = ctl_q.win;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q          <= '0;
      ctl_q.clr_pend <= 1'b1;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_comb begin
    eng_d = eng_q;
    eng_d.rdata = eng_q.mask[buf_raddr] ? buf_mem[buf_raddr] : ERASED_WORD;

    if (eeprom_write_start | buf_clear | (ctl_q.clr_pend & eng_idle)) begin
      eng_d.mask = 64'h0000000000000000;
    end else if (load_word) begin
      eng_d.mask[word_sel] = 1'b1;
    end

    case (eng_q.state)
      E_IDLE: begin
        if (start_op) begin
          eng_d.state    = E_RUN;
          eng_d.op       = start_kind;
          eng_d.page     = page_sel;
          eng_d.no_read_while_write_section     = (page_sel >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
          eng_d.lock_new = r_data[LOCK_MSB:LOCK_LSB];
          eng_d.div      = 6'h00;
          eng_d.ticks    = 12'h000;
        end
      end
      E_RUN: begin
        if (eng_q.div == DIV_LAST) begin
          eng_d.div   = 6'h00;
          eng_d.ticks = eng_q.ticks + 12'h001;
          if (eng_q.ticks == TICK_LAST) begin
            eng_d.state = E_DONE;
          end
        end else begin
          eng_d.div = eng_q.div + 6'h01;
        end
      end
      E_DONE: begin
        eng_d.state = E_IDLE;
        if (eng_q.op == OP_LOCK) begin
          eng_d.lock_bits = eng_q.lock_bits & eng_q.lock_new;
        end
        if (eng_q.op == OP_WRITE) begin
          eng_d.mask = 64'h0000000000000000;
        end
      end
      default: begin
        eng_d.state = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      eng_q           <= '0;
      eng_q.state     <= E_IDLE;
      eng_q.lock_bits <= LOCK_RESET;
      eng_q.rdata     <= ERASED_WORD;
    end else begin
      eng_q <= eng_d;
    end
  end

  // any load order, first load wins
  always_ff @(posedge pclk) begin
    if (load_word & ~eng_q.mask[word_sel]) begin
      buf_mem[word_sel] <= r_data;
    end
  end

  assign prdata            = ctl_q.prdata;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & ~addr_hit;
  assign buf_rdata         = eng_q.rdata;
  assign lpm_data          = ctl_q.lpm_data;
  assign lpm_hit           = ctl_q.lpm_hit;
  assign flash_busy        = ~eng_idle;
  assign flash_erase       = ~eng_idle & (eng_q.op == OP_ERASE);
  assign flash_write       = ~eng_idle & (eng_q.op == OP_WRITE);
  assign flash_lock        = ~eng_idle & (eng_q.op == OP_LOCK);
  assign flash_page        = eng_q.page;
  assign flash_done        = (eng_q.state == E_DONE);
  assign lock_bits         = eng_q.lock_bits;
  assign section_busy_flag = ctl_q.busy | rww_active;
  assign rww_read_block    = ctl_q.busy | rww_active;
  assign cpu_halt          = ~eng_idle & eng_q.no_read_while_write_section & (eng_q.op != OP_LOCK);
  assign irq               = ctl_q.irq_en & global_irq_en & ~ctl_q.spm_en;

endmodule

`default_nettype wire

/* File: verification/core_model.sv */
/*
  processor core model issuing store and load program instructions.
  assumes pclk from the bench; each instruction lasts one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic        pclk,
  output logic             spm_exec,
  output logic             lpm_exec,
  output logic      [15:0] z_ptr,
  output logic      [15:0] r_data
);
  initial begin
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    z_ptr = 16'hFFFF;
    r_data = 16'hFFFF;
  end

  // no interrupt taken inside the timed window
  task automatic issue(input logic store, input logic [15:0] z, input logic [15:0] r);
    @(posedge pclk);
    spm_exec <= store;
    lpm_exec <= !store;
    z_ptr <= z;
    r_data <= r;
    @(posedge pclk);
    spm_exec <= 1'b0;
    lpm_exec <= 1'b0;
    // operands are not held once the instruction is gone
    z_ptr <= ~z;
    r_data <= ~r;
  endtask
endmodule
`default_nettype wire

/* File: verification/flash_self_program_properties.sv */
/*
  port checker of the flash sequencer: timed windows, busy, halt, op time.
  assumes one pclk domain; bound to every sequencer instance below.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_properties
  import flash_self_program_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        spm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic        global_irq_en,
  input wire logic        eeprom_busy,
  input wire logic        flash_busy,
  input wire logic        flash_write,
  input wire logic        flash_lock,
  input wire logic [7:0]  flash_page,
  input wire logic        flash_done,
  input wire logic        section_busy_flag,
  input wire logic        rww_read_block,
  input wire logic        cpu_halt,
  input wire logic        irq
);
  localparam int MIN_CYC = 185000;
  localparam int MAX_CYC = 225000;
  logic [17:0] busy_cnt_q;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n)
      busy_cnt_q <= 18'h0;
    else
      busy_cnt_q <= flash_busy ? busy_cnt_q + 18'h1 : 18'h0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);

  // irq high at the write edge proves the enable bit was clear
  sequence ctrl_wr(cmd);
    psel && penable && pwrite && paddr == CTRL_ADDR && pwdata[4:0] == cmd && irq && !eeprom_busy;
  endsequence
  sequence spm_go;
    spm_exec && !eeprom_busy;
  endsequence

  AST_WRITE_START: assert property (ctrl_wr(CMD_WRITE) ##[1:4] spm_go |=>
    flash_write && flash_page == $past(z_ptr[Z_PAGE_MSB:Z_PAGE_LSB])) else $error("page write not started");
  AST_LOAD_CLEARS: assert property (ctrl_wr(CMD_LOAD) ##[1:4] spm_go |=> !section_busy_flag)
    else $error("load left busy flag");
  AST_EE_REFUSE: assert property (eeprom_busy && spm_exec && !flash_busy |=> !flash_busy)
    else $error("op started during eeprom write");
  AST_IRQ_GATED: assert property (irq |-> global_irq_en && !flash_busy)
    else $error("irq not gated");
  AST_RWW_BLOCK: assert property (flash_busy && !flash_done && !flash_lock && flash_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
    |-> rww_read_block && section_busy_flag) else $error("section not blocked");
  AST_NO_READ_WHILE_WRITE_SECTION_HALT: assert property (flash_busy && !flash_done && !flash_lock && flash_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
    |-> cpu_halt) else $error("cpu not halted");
  AST_LOCK_FREE: assert property (flash_lock |-> !cpu_halt)
    else $error("halt during lock op");
  AST_KEEP_OP: assert property (disable iff (!por_n) flash_busy && !flash_done |=> flash_busy)
    else $error("op abandoned");
  AST_DONE_END: assert property (disable iff (!por_n) flash_done |=> !flash_busy)
    else $error("busy after done");
  AST_PROG_TIME: assert property (disable iff (!por_n) $fell(flash_busy) |->
    busy_cnt_q >= MIN_CYC && busy_cnt_q <= MAX_CYC) else $error("op time out of range");
endmodule

bind flash_self_program_sequencer flash_self_program_properties flash_self_program_properties_inst (
  .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .spm_exec, .z_ptr, .global_irq_en,
  .eeprom_busy, .flash_busy, .flash_write, .flash_lock, .flash_page, .flash_done, .section_busy_flag,
  .rww_read_block, .cpu_halt, .irq);
`default_nettype wire

/* File: verification/flash_self_program_sequencer_test.sv */
/*
  testbench of the flash sequencer: control access, buffer, readback, page write.
  assumes the core model and the bound property checker.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sequencer_test;
  import flash_self_program_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
  logic        global_irq_en, eeprom_busy, eeprom_write_start, spm_exec, lpm_exec, lpm_hit;
  logic        flash_busy, flash_write, flash_done, section_busy_flag, rww_read_block, cpu_halt, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] z_ptr, r_data, buf_rdata;
  logic [7:0]  lpm_data, flash_page;
  logic [5:0]  buf_raddr;
  int          fail_count, n_checks, cyc, n;

  flash_self_program_sequencer flash_self_program_sequencer_inst (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .spm_exec, .lpm_exec, .z_ptr, .r_data, .global_irq_en, .eeprom_busy, .eeprom_write_start,
    .fuse_low_byte(8'hA5), .fuse_high_byte(8'h3C), .buf_raddr, .buf_rdata, .lpm_data, .lpm_hit,
    .flash_busy, .flash_erase(), .flash_write, .flash_lock(), .flash_page, .flash_done, .lock_bits(),
    .section_busy_flag, .rww_read_block, .cpu_halt, .irq);
  core_model core_model_inst (.pclk, .spm_exec, .lpm_exec, .z_ptr, .r_data);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 200000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_ctrl(input logic [31:0] exp);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("ctrl", exp, rd);
  endtask

  // each word loaded once between clears
  task automatic load(input logic [5:0] w, input logic [15:0] d);
    apb(1'b1, CTRL_ADDR, 32'h81);
    core_model_inst.issue(1'b1, {9'h0, w, 1'b0}, d);
  endtask

  task automatic buf_chk(input logic [5:0] w, input logic [15:0] exp);
    @(posedge pclk);
    buf_raddr <= w;
    repeat (2) @(posedge pclk);
    check("buf", 32'(exp), 32'(buf_rdata));
  endtask

  task automatic readback(input logic [15:0] z, input logic [7:0] exp);
    apb(1'b1, CTRL_ADDR, 32'h89);
    core_model_inst.issue(1'b0, z, 16'h0);
    @(posedge pclk);
    check("hit", 32'h1, 32'(lpm_hit));
    check("byte", 32'(exp), 32'(lpm_data));
  endtask

  initial begin
    {psel, penable, pwrite, eeprom_busy, eeprom_write_start, presetn, por_n} = 7'h0;
    {paddr, pwdata, buf_raddr, cyc, fail_count, n_checks} = '0;
    global_irq_en = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    check("slverr", 32'h1, 32'(err));
    rd_ctrl(32'h0);
    apb(1'b1, CTRL_ADDR, 32'h80);
    @(posedge pclk);
    check("irq", 32'h1, 32'(irq));
    global_irq_en <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    check("irq", 32'h0, 32'(irq));
    global_irq_en <= 1'b1;
    readback(Z_FUSE_LOW, 8'hA5);
    readback(Z_LOCK_BYTE, 8'hFF);
    readback(Z_FUSE_HIGH, 8'h3C);
    rd_ctrl(32'h80);
    apb(1'b1, CTRL_ADDR, 32'h89);
    repeat (6) @(posedge pclk);
    rd_ctrl(32'h80);
    eeprom_busy <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h89);
    rd_ctrl(32'h80);
    core_model_inst.issue(1'b0, Z_LOCK_BYTE, 16'h0);
    @(posedge pclk);
    check("hit", 32'h0, 32'(lpm_hit));
    eeprom_busy <= 1'b0;
    load(6'd5, 16'h1234);
    load(6'd0, 16'hABCD);
    buf_chk(6'd5, 16'h1234);
    buf_chk(6'd0, 16'hABCD);
    buf_chk(6'd7, ERASED_WORD);
    eeprom_write_start <= 1'b1;
    @(posedge pclk);
    eeprom_write_start <= 1'b0;
    buf_chk(6'd5, ERASED_WORD);
    load(6'd5, 16'h1234);
    apb(1'b1, CTRL_ADDR, 32'h91);
    buf_chk(6'd5, ERASED_WORD);
    load(6'd5, 16'h1234);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    buf_chk(6'd5, ERASED_WORD);
    apb(1'b1, CTRL_ADDR, 32'h83);
    eeprom_busy <= 1'b1;
    core_model_inst.issue(1'b1, 16'h0080, 16'h0);
    @(posedge pclk);
    check("busy", 32'h0, 32'(flash_busy));
    eeprom_busy <= 1'b0;
    repeat (6) @(posedge pclk);
    load(6'd0, 16'hBEEF);
    apb(1'b1, CTRL_ADDR, 32'h85);
    core_model_inst.issue(1'b1, 16'h0280, 16'h0);
    @(posedge pclk);
    check("op", 32'h3, {30'h0, flash_busy, flash_write});
    check("page", 32'h5, 32'(flash_page));
    check("block", 32'h6, {29'h0, rww_read_block, section_busy_flag, cpu_halt});
    n = 0;
    while (flash_done !== 1'b1) begin
      @(posedge pclk);
      n++;
      presetn <= !(n >= 1000 && n < 1003);
    end
    check("time", 32'h1, 32'(n >= 184999 && n <= 224999));
    @(posedge pclk);
    check("busy", 32'h0, 32'(flash_busy));
    buf_chk(6'd0, ERASED_WORD);
    rd_ctrl(32'h40);
    // the section is reopened by a load before any use
    load(6'd1, 16'h0001);
    @(posedge pclk);
    check("flag", 32'h0, 32'(section_busy_flag));
    stop_test();
  end
endmodule
`default_nettype wire
